// [core/dwpx_pkg.sv]
package dwpx_pkg;

	// Field positions inside the attribute words, and field widths
	localparam int WB_MODE_BIT   = 19;
	localparam int ENABLE_BIT    = 0;
	localparam int ATTR_W        = 32;
	localparam int PIPE_W        = 2;
	localparam int LINE_CNT_W    = 12;

	// Reset values and field encodings
	localparam logic [ATTR_W-1:0] ATTR_RST = 32'h0000_0000;
	localparam logic              ENA_SET  = 1'b1;
	localparam logic              ENA_CLR  = 1'b0;
	localparam logic [PIPE_W-1:0] ROUTE_NONE = 2'h0;
	localparam logic [PIPE_W-1:0] ROUTE_WB   = 2'h1;
	localparam logic [PIPE_W-1:0] ROUTE_LCD  = 2'h2;

	// Default number of lines in one memory-to-memory pass
	localparam int PASS_LINES = 16;

	// Exit sequence progress as seen by the hardware
	typedef enum logic [2:0] {
		DWPX_IDLE,
		DWPX_COPY,
		DWPX_DONE,
		DWPX_PIPE_OFF,
		DWPX_WB_TOGGLED,
		DWPX_READY
	} dwpx_state_t;

	// Software write request into the attribute words
	typedef struct packed {
		logic              wb_wr;
		logic              wb_mode;
		logic              wb_enable;
		logic              pipe_wr;
		logic              pipe_enable;
		logic              route_wr;
		logic [PIPE_W-1:0] route;
	} dwpx_req_t;

	// Status reported back to software
	typedef struct packed {
		logic              wb_enable;
		logic              wb_mode;
		logic              pipe_enable;
		logic [PIPE_W-1:0] route;
		logic              pass_done;
		logic              sync_lost;
		logic              frame_bad;
		logic              exit_ok;
	} dwpx_stat_t;

endpackage

// [core/dwpx_sync.sv]
`timescale 1ns/100ps
// Two-stage synchroniser for pin-level inputs
module dwpx_sync (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_reg <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			s1_reg <= d_i;
			q_o    <= s1_reg;
		end
	end
endmodule

// [core/dwpx_top.sv]
`timescale 1ns/100ps
// Overview of operation
// - Mode bit 19 of writeback attributes selects memory-to-memory copy.
// - Pass completion clears the writeback enable bit automatically.
// - Pass completion leaves the source pipe enable bit set.
// - Rerouting an enabled pipe to the panel raises sync-lost, one bad frame.
module dwpx_top #(
	parameter int LINES = dwpx_pkg::PASS_LINES
) (
	input  wire logic                clk_sys_i,
	input  wire logic                resetn_i,
	input  wire dwpx_pkg::dwpx_req_t req_i,
	input  wire logic                line_done_i,
	input  wire logic                panel_vsync_i,
	output dwpx_pkg::dwpx_stat_t     stat_o,
	output logic [dwpx_pkg::ATTR_W-1:0] wb_attr_o,
	output logic [dwpx_pkg::ATTR_W-1:0] vid_attr_o
);
	import dwpx_pkg::*;

	localparam logic [LINE_CNT_W-1:0] LAST_LINE =
		LINE_CNT_W'(LINES - 1);

	// Control state in one record; the vsync edge register and the output registers sit apart
	typedef struct packed {
		dwpx_state_t           st;
		logic                  wb_en;
		logic                  wb_mode;
		logic                  pipe_en;
		logic [PIPE_W-1:0]     route;
		logic [LINE_CNT_W-1:0] lines;
		logic                  pass_done;
		logic                  sync_lost;
		logic                  frame_bad;
		logic                  exit_ok;
	} dwpx_all_t;

	dwpx_all_t s_reg;
	dwpx_all_t s_next;
	logic      vsync_s;
	logic      vsync_d_reg;
	logic      frame_start;

	// Panel vsync arrives from another domain
	dwpx_sync u_vsync (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.d_i       (panel_vsync_i),
		.q_o       (vsync_s)
	);

	// Rising edge of synchronised vsync marks a frame start
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vsync_d_reg <= 1'b0;
		end else begin
			vsync_d_reg <= vsync_s;
		end
	end
	assign frame_start = vsync_s & ~vsync_d_reg;

	// True when a pass is running
	function automatic logic copying(input dwpx_all_t s);
		return s.wb_en && s.wb_mode && s.route == ROUTE_WB;
	endfunction

	// Next-state logic
	always_comb begin
		s_next           = s_reg;
		s_next.pass_done = 1'b0;
		s_next.sync_lost = 1'b0;
		// Software writes to the writeback word
		if (req_i.wb_wr) begin
			s_next.wb_mode = req_i.wb_mode;
			s_next.wb_en   = req_i.wb_enable;
			if (req_i.wb_enable && req_i.wb_mode)
				s_next.lines = '0;
		end
		if (req_i.pipe_wr)
			s_next.pipe_en = req_i.pipe_enable;
		// Routing change; no frame alignment on an enabled pipe
		if (req_i.route_wr) begin
			s_next.route = req_i.route;
			if (req_i.route == ROUTE_LCD && s_reg.route != ROUTE_LCD &&
			    s_next.pipe_en) begin
				s_next.sync_lost = 1'b1;
				s_next.frame_bad = 1'b1;
			end
		end
		// Bad frame lasts until the panel starts a new one
		if (frame_start && !(req_i.route_wr && s_next.sync_lost))
			s_next.frame_bad = 1'b0;
		// Line counting during the pass; a write to the writeback word wins the cycle
		if (copying(s_reg) && line_done_i && !req_i.wb_wr) begin
			if (s_reg.lines == LAST_LINE) begin
				s_next.wb_en     = ENA_CLR;
				s_next.pass_done = 1'b1;
				// Pipe enable is left untouched here
			end else begin
				s_next.lines = s_reg.lines + LINE_CNT_W'(1);
			end
		end
		// Track the clean exit sequence software should follow
		unique case (s_reg.st)
			DWPX_IDLE: begin
				s_next.exit_ok = 1'b0;
				if (copying(s_next))
					s_next.st = DWPX_COPY;
			end
			DWPX_COPY: begin
				if (s_next.pass_done)
					s_next.st = DWPX_DONE;
			end
			DWPX_DONE: begin
				if (!s_next.pipe_en)
					s_next.st = DWPX_PIPE_OFF;
			end
			DWPX_PIPE_OFF: begin
				if (req_i.wb_wr && !req_i.wb_enable && s_reg.wb_en)
					s_next.st = DWPX_WB_TOGGLED;
				else if (s_next.pipe_en)
					s_next.st = DWPX_DONE; // Pipe back on undoes the step
			end
			DWPX_WB_TOGGLED: begin
				if (s_next.pipe_en && s_next.route == ROUTE_LCD) begin
					s_next.st      = DWPX_READY;
					s_next.exit_ok = 1'b1;
				end
			end
			DWPX_READY: begin
				if (copying(s_next)) begin
					s_next.st      = DWPX_COPY;
					s_next.exit_ok = 1'b0;
				end
			end
			default: s_next.st = DWPX_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_reg <= '{st: DWPX_IDLE, route: ROUTE_NONE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stat_o     <= '0;
			wb_attr_o  <= ATTR_RST;
			vid_attr_o <= ATTR_RST;
		end else begin
			stat_o     <= '{wb_enable: s_next.wb_en,
			                wb_mode: s_next.wb_mode,
			                pipe_enable: s_next.pipe_en,
			                route: s_next.route,
			                pass_done: s_next.pass_done,
			                sync_lost: s_next.sync_lost,
			                frame_bad: s_next.frame_bad,
			                exit_ok: s_next.exit_ok};
			wb_attr_o  <= ATTR_RST;
			wb_attr_o[WB_MODE_BIT] <= s_next.wb_mode;
			wb_attr_o[ENABLE_BIT]  <= s_next.wb_en;
			vid_attr_o <= ATTR_RST;
			vid_attr_o[ENABLE_BIT] <= s_next.pipe_en;
		end
	end

	// Checks; the status word is registered from the same next state,
	// so it must agree with the state record in the very same cycle
	AST_AUTO_CLEAR: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		s_reg.pass_done |-> !s_reg.wb_en && !wb_attr_o[ENABLE_BIT])
		else $error("writeback enable not cleared at pass end");
	AST_PIPE_KEPT: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		(copying(s_reg) && s_reg.pipe_en && !req_i.pipe_wr) |=>
		s_reg.pipe_en)
		else $error("pipe enable dropped by hardware");
	AST_SYNC_LOST: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		(req_i.route_wr && req_i.route == ROUTE_LCD &&
		 s_reg.route != ROUTE_LCD && s_reg.pipe_en && !req_i.pipe_wr)
		|=> s_reg.sync_lost && stat_o.sync_lost && stat_o.frame_bad)
		else $error("sync-lost missing on unaligned attach");
	AST_MODE_BIT: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		req_i.wb_wr |=> wb_attr_o[WB_MODE_BIT] == $past(req_i.wb_mode))
		else $error("mode bit not stored");
	AST_EXIT_ORDER: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		$rose(s_reg.exit_ok) |-> s_reg.pipe_en &&
		s_reg.route == ROUTE_LCD && !s_reg.wb_en)
		else $error("exit flagged out of order");
	AST_PIPE_OFF: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		(s_reg.st == DWPX_PIPE_OFF) |-> !s_reg.pipe_en)
		else $error("pipe-off step with pipe enabled");

	// A disabled pipe may join any route without losing sync
	AST_QUIET_ATTACH: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		(req_i.route_wr && !req_i.pipe_wr && !s_reg.pipe_en) |=>
		!s_reg.sync_lost && !stat_o.sync_lost)
		else $error("sync-lost raised for a disabled pipe");

	// Damage is limited to one frame: the next frame start heals it
	AST_BAD_FRAME_END: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		(s_reg.frame_bad && frame_start && !req_i.route_wr) |=>
		!s_reg.frame_bad && !stat_o.frame_bad)
		else $error("corrupted frame outlived a frame start");

	// Main scenarios worth seeing at least once
	COV_PASS: cover property (@(posedge clk_sys_i) s_reg.pass_done);
	COV_LOST: cover property (@(posedge clk_sys_i) s_reg.sync_lost);
	COV_EXIT: cover property (@(posedge clk_sys_i) $rose(s_reg.exit_ok));
	COV_STEP: cover property (@(posedge clk_sys_i)
		s_reg.st == DWPX_PIPE_OFF);
endmodule

// [dv/dwpx_far_model.sv]
`timescale 1ns/100ps
// Memory answers a written line every fourth cycle; panel vsync runs free
module dwpx_far_model (
	input  wire logic        clk_sys_i,
	input  wire logic [31:0] wb_attr_i,
	output logic             line_done_o,
	output logic             vsync_o
);
	logic [3:0] tick_reg;

	initial begin
		tick_reg = 4'h0;
		line_done_o = 1'h0;
		vsync_o = 1'h0;
	end

	// Lines land only while the writeback enable and mode bits are set; the slow pace mimics memory stalls
	always @(negedge clk_sys_i) begin
		tick_reg <= tick_reg + 4'h1;
		line_done_o <= wb_attr_i[0] && wb_attr_i[19] && tick_reg[1:0] == 2'h0;
		if (tick_reg == 4'h0) begin
			vsync_o <= ~vsync_o;
		end
	end
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
	import dwpx_pkg::*;
	localparam int NL = 4;
	localparam dwpx_req_t START = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, ROUTE_WB};
	localparam dwpx_req_t P_OFF = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 2'h0};
	localparam dwpx_req_t WB_ON = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h0};
	localparam dwpx_req_t WB_OFF = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0};
	localparam dwpx_req_t TO_LCD =
		'{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, ROUTE_LCD};
	localparam dwpx_req_t P_ON = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 2'h0};
	logic              clk_sys_i;
	logic              resetn_i;
	logic              line_done;
	logic              vsync;
	dwpx_req_t         req;
	dwpx_stat_t        stat;
	logic [ATTR_W-1:0] wb_attr;
	logic [ATTR_W-1:0] vid_attr;
	int                fail_count;
	int                total_checks;
	int                ld_cnt;
	int                pd_cnt;
	int                sl_cnt;
	logic              wb_en_seen;

	dwpx_top #(.LINES(NL)) dut (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req),
		.line_done_i(line_done), .panel_vsync_i(vsync), .stat_o(stat),
		.wb_attr_o(wb_attr), .vid_attr_o(vid_attr)
	);
	dwpx_far_model far (
		.clk_sys_i(clk_sys_i), .wb_attr_i(wb_attr),
		.line_done_o(line_done), .vsync_o(vsync)
	);

	initial begin
		clk_sys_i = 1'h0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// One-cycle pulses are counted on every falling edge; a line counts
	// only if writeback was on at the edge that took it, since the last
	// line already shows the enable cleared by the time it is seen here
	always @(negedge clk_sys_i) begin
		if (line_done === 1'h1 && wb_en_seen === 1'h1) ld_cnt++;
		wb_en_seen = stat.wb_enable;
		if (stat.pass_done === 1'h1) pd_cnt++;
		if (stat.sync_lost === 1'h1) sl_cnt++;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic c, input string m);
		total_checks++;
		if (c !== 1'h1) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic give_up();
		fail_count++;
		$display("BAD %0t wait ran out", $time);
		tally_and_finish();
	endtask

	// Reset and counters cleared; the first request follows release
	task automatic do_reset();
		resetn_i = 1'h0;
		req = '0;
		repeat (20) @(negedge clk_sys_i);
		resetn_i = 1'h1;
		ld_cnt = 0;
		pd_cnt = 0;
		sl_cnt = 0;
	endtask

	// One strobe cycle, then a settle delay so the monitor has run
	task automatic drive(input dwpx_req_t r);
		@(negedge clk_sys_i);
		req = r;
		@(negedge clk_sys_i);
		req = '0;
		#1;
	endtask

	task automatic run_copy();
		drive(START);
		for (int i = 0; i < 400 && pd_cnt == 0; i++) begin
			@(negedge clk_sys_i);
			#1;
		end
		if (pd_cnt == 0) give_up();
	endtask

	task automatic sc_pass();
		do_reset();
		run_copy();
		check(ld_cnt == NL && pd_cnt == 1, "pass length");
		check(wb_attr === 32'h0008_0000, "wb attr after pass");
		check(stat.wb_mode === 1'h1, "mode status");
		check(vid_attr === 32'h0000_0001, "pipe dropped");
		check(stat.pipe_enable === ENA_SET, "pipe status");
		check(stat.wb_enable === ENA_CLR, "wb status");
	endtask

	// Ordered exit: each step waits a cycle to land before the next
	task automatic sc_exit();
		do_reset();
		run_copy();
		drive(P_OFF);
		check(vid_attr === 32'h0000_0000, "pipe not off");
		drive(WB_ON);
		check(wb_attr === 32'h0008_0001, "wb not set");
		drive(WB_OFF);
		drive(TO_LCD);
		check(stat.route === ROUTE_LCD, "route");
		drive(P_ON);
		check(stat.exit_ok === 1'h1, "exit not seen");
		check(sl_cnt == 0 && stat.frame_bad === 1'h0, "false loss");
	endtask

	// Hot reroute of a still-enabled pipe corrupts one frame
	task automatic sc_hot();
		do_reset();
		run_copy();
		drive(TO_LCD);
		check(sl_cnt == 1 && stat.frame_bad === 1'h1, "no loss");
		check(stat.exit_ok === 1'h0, "exit flagged");
		for (int i = 0; i < 80 && stat.frame_bad !== 1'h0; i++) begin
			@(negedge clk_sys_i);
		end
		if (stat.frame_bad !== 1'h0) give_up();
		check(stat.frame_bad === 1'h0 && sl_cnt == 1, "frame stuck");
	endtask

	initial begin
		resetn_i = 1'h0;
		req = '0;
		sc_pass();
		sc_exit();
		sc_hot();
		tally_and_finish();
	end
endmodule
